/* design/scale_alarm_pkg.sv */
// Constants shared by the channel scaling and alarm block: register map,
// field positions, reset values, input type codes and scaling limits.
// Assumes a 32-bit Avalon-MM register bus and raw samples from a converter on core_clk.
package scale_alarm_pkg;
	// Register byte offsets, one aligned 32-bit word each.
	localparam logic [5:0] OFF_CONFIG = 6'h00;
	localparam logic [5:0] OFF_TOP = 6'h04;
	localparam logic [5:0] OFF_BOTTOM = 6'h08;
	localparam logic [5:0] OFF_EXT = 6'h0C;
	localparam logic [5:0] OFF_THR1 = 6'h10;
	localparam logic [5:0] OFF_HYST1 = 6'h14;
	localparam logic [5:0] OFF_THR2 = 6'h18;
	localparam logic [5:0] OFF_HYST2 = 6'h1C;
	localparam logic [5:0] OFF_BIAS = 6'h20;
	localparam logic [5:0] OFF_STATUS = 6'h24;
	localparam logic [5:0] OFF_VALUE = 6'h28;
	localparam logic [5:0] OFF_PERCENT = 6'h2C;
	localparam logic [5:0] OFF_NAME0 = 6'h30;
	localparam logic [5:0] OFF_NAME1 = 6'h34;
	localparam logic [5:0] OFF_NAME2 = 6'h38;
	localparam logic [5:0] OFF_UNIT = 6'h3C;
	// Field positions inside the configuration and margin words.
	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_FILT_LSB = 5;
	localparam int CFG_DEC_LSB = 8;
	localparam int CFG_FAHR_BIT = 10;
	localparam int CFG_WIRE_LSB = 11;
	localparam int CFG_DIR1_BIT = 13;
	localparam int CFG_DIR2_BIT = 14;
	localparam int EXT_LOWER_LSB = 16;
	// Reset values.
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic signed [15:0] TOP_RST = 16'sh03E8;
	localparam logic signed [15:0] BOTTOM_RST = 16'sh0000;
	// Filter level limit and the fixed-point fraction of the smoother.
	localparam logic [2:0] FILT_MAX = 3'h5;
	localparam int FILT_FRAC = 8;
	// Scale point and bias limits, in display counts and tenths of a degree.
	localparam int SCALE_LIMIT = 9999;
	localparam int BIAS_TC_LIMIT = 2990;
	localparam int BIAS_RTD_LIMIT = 299;
	localparam int FAHR_OFFSET = 320;
	localparam int PERCENT_FULL = 1000;
	// Input type codes.
	typedef enum logic [4:0] {
		IN_OFF = 5'h00, IN_MA_0_20 = 5'h01, IN_MA_4_20 = 5'h02, IN_V_0_5 = 5'h03,
		IN_V_1_5 = 5'h04, IN_V_0_10 = 5'h05, IN_V_2_10 = 5'h06, IN_MV_60 = 5'h07,
		IN_MV_75 = 5'h08, IN_MV_100 = 5'h09, IN_MV_150 = 5'h0A, IN_PT100 = 5'h0B,
		IN_PT500 = 5'h0C, IN_PT1000 = 5'h0D, IN_TC_K = 5'h0E, IN_TC_S = 5'h0F,
		IN_TC_J = 5'h10, IN_TC_T = 5'h11, IN_TC_N = 5'h12, IN_TC_R = 5'h13,
		IN_TC_B = 5'h14, IN_TC_E = 5'h15
	} input_type_e;
	// Processing states, Gray coded along the sample path.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_FILTER = 2'b01, ST_SCALE = 2'b11, ST_ALARM = 2'b10
	} proc_state_e;
endpackage : scale_alarm_pkg

/* design/channel_scaling_and_alarms.sv */
// Per-channel post-processing: filtering, scaling, range check, temperature bias and
// two threshold alarms, with an Avalon-MM register slave that uses waitrequest.
// Assumes raw samples arrive on core_clk with a valid/ready handshake, in hundredths
// of mA, V or mV for span inputs and in tenths of a degree Celsius for sensors.
module channel_scaling_and_alarms
	import scale_alarm_pkg::*;
#(
	parameter bit TEMP_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic sample_valid,
	input wire logic signed [15:0] sample_data,
	output logic sample_ready,
	output logic first_alarm,
	output logic second_alarm,
	output logic over_range_indication,
	output logic under_range_indication,
	output logic signed [15:0] display_value,
	output logic signed [15:0] percent_value,
	output logic [1:0] decimal_places,
	output logic [1:0] wire_count,
	output logic result_strobe
);
	// All state of the block in one record.
	typedef struct packed {
		proc_state_e state;
		logic [31:0] config_word;
		logic signed [15:0] top;
		logic signed [15:0] bottom;
		logic [10:0] ext_upper;
		logic [10:0] ext_lower;
		logic signed [15:0] thr1;
		logic signed [15:0] hyst1;
		logic signed [15:0] thr2;
		logic signed [15:0] hyst2;
		logic signed [15:0] bias;
		logic [31:0] name0;
		logic [31:0] name1;
		logic [31:0] name2;
		logic [31:0] unit_label;
		logic signed [15:0] raw;
		logic signed [31:0] filt;
		logic filt_primed;
		logic signed [15:0] value;
		logic signed [15:0] pct;
		logic over;
		logic under;
		logic al1;
		logic al2;
		logic result_ok;
		logic strobe;
		logic ack;
		logic [31:0] rdata;
	} state_s;

	state_s cur_q;
	state_s nxt_d;

	// Saturates a value to a symmetric limit.
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
			input logic signed [31:0] lim);
		if (v > lim) begin
			clamp = lim;
		end else if (v < -lim) begin
			clamp = -lim;
		end else begin
			clamp = v;
		end
	endfunction : clamp

	// True for current and voltage inputs.
	function automatic logic is_span(input logic [4:0] t);
		is_span = (t >= IN_MA_0_20) && (t <= IN_V_2_10);
	endfunction : is_span

	// True for millivolt inputs.
	function automatic logic is_mv(input logic [4:0] t);
		is_mv = (t >= IN_MV_60) && (t <= IN_MV_150);
	endfunction : is_mv

	// True for resistance thermometer inputs in the temperature variant only.
	function automatic logic is_rtd(input logic [4:0] t);
		is_rtd = TEMP_VARIANT && (t >= IN_PT100) && (t <= IN_PT1000);
	endfunction : is_rtd

	// True for thermocouple inputs.
	function automatic logic is_tc(input logic [4:0] t);
		is_tc = (t >= IN_TC_K) && (t <= IN_TC_E);
	endfunction : is_tc

	// Whether this variant serves the given type at all.
	function automatic logic type_live(input logic [4:0] t);
		if (TEMP_VARIANT) begin
			type_live = is_mv(t) || is_rtd(t) || is_tc(t);
		end else begin
			type_live = is_span(t);
		end
	endfunction : type_live

	// Nominal span bottom in hundredths of the input unit (live zero where there is one).
	function automatic logic signed [31:0] span_lo(input logic [4:0] t);
		case (t)
			IN_MA_4_20: span_lo = 32'sd400;
			IN_V_1_5: span_lo = 32'sd100;
			IN_V_2_10: span_lo = 32'sd200;
			default: span_lo = 32'sd0;
		endcase
	endfunction : span_lo

	// Nominal span top in hundredths of the input unit.
	function automatic logic signed [31:0] span_hi(input logic [4:0] t);
		case (t)
			IN_MA_0_20, IN_MA_4_20: span_hi = 32'sd2000;
			IN_V_0_5, IN_V_1_5: span_hi = 32'sd500;
			IN_V_0_10, IN_V_2_10: span_hi = 32'sd1000;
			IN_MV_60: span_hi = 32'sd6000;
			IN_MV_75: span_hi = 32'sd7500;
			IN_MV_100: span_hi = 32'sd10000;
			IN_MV_150: span_hi = 32'sd15000;
			default: span_hi = 32'sd1;
		endcase
	endfunction : span_hi

	// Largest upper margin per span, in hundredths of the input unit.
	function automatic logic signed [31:0] upper_lim(input logic [4:0] t);
		case (t)
			IN_MA_0_20, IN_MA_4_20: upper_lim = 32'sd199;
			IN_V_0_5, IN_V_1_5: upper_lim = 32'sd49;
			IN_V_0_10, IN_V_2_10: upper_lim = 32'sd99;
			IN_MV_60, IN_MV_75, IN_MV_100: upper_lim = 32'sd999;
			IN_MV_150: upper_lim = 32'sd1499;
			default: upper_lim = 32'sd0;
		endcase
	endfunction : upper_lim

	// Largest lower margin; zero-based spans have none.
	function automatic logic signed [31:0] lower_lim(input logic [4:0] t);
		case (t)
			IN_MA_4_20: lower_lim = 32'sd399;
			IN_V_1_5: lower_lim = 32'sd99;
			IN_V_2_10: lower_lim = 32'sd199;
			default: lower_lim = 32'sd0;
		endcase
	endfunction : lower_lim

	// One alarm with hysteresis: trips past threshold shifted by hysteresis and holds
	// until the value returns over the bare threshold, so noise cannot chatter it.
	function automatic logic alarm_next(input logic cur, input logic above,
			input logic signed [31:0] v, input logic signed [31:0] thr,
			input logic signed [31:0] hyst);
		logic signed [31:0] h;
		h = (hyst > 0) ? hyst : 32'sd0;
		if (above) begin
			alarm_next = (v > thr + h) || (cur && (v > thr));
		end else begin
			alarm_next = (v < thr - h) || (cur && (v < thr));
		end
	endfunction : alarm_next

	// Decoded configuration fields.
	logic [4:0] in_type;
	logic [2:0] filt_level;
	logic margins_on;
	assign in_type = cur_q.config_word[CFG_TYPE_LSB +: 5];
	assign filt_level = cur_q.config_word[CFG_FILT_LSB +: 3];
	// Margins apply to span inputs, and in the temperature variant to millivolt only.
	assign margins_on = TEMP_VARIANT ? is_mv(in_type) : is_span(in_type);

	// Bus handshake: one wait cycle, then the answer; read data is registered.
	assign waitrequest = (read | write) & (~cur_q.ack | ~clk_en);
	assign readdata = cur_q.rdata;
	assign sample_ready = (cur_q.state == ST_IDLE) && clk_en;
	assign first_alarm = cur_q.al1;
	assign second_alarm = cur_q.al2;
	assign over_range_indication = cur_q.over;
	assign under_range_indication = cur_q.under;
	assign display_value = cur_q.value;
	assign percent_value = cur_q.pct;
	assign decimal_places = cur_q.config_word[CFG_DEC_LSB +: 2];
	assign wire_count = is_rtd(in_type) ? cur_q.config_word[CFG_WIRE_LSB +: 2] : 2'h0;
	assign result_strobe = cur_q.strobe;

	// Next-state logic for the register file and the sample pipeline.
	always_comb begin
		logic signed [31:0] lo_pt;
		logic signed [31:0] hi_pt;
		logic signed [31:0] x;
		logic signed [31:0] v;
		logic signed [31:0] up_m;
		logic signed [31:0] lo_m;
		logic signed [31:0] blim;
		logic [2:0] lvl;
		lo_pt = 32'(cur_q.bottom);
		hi_pt = 32'(cur_q.top);
		x = (cur_q.filt >>> FILT_FRAC);
		v = 32'sd0;
		up_m = 32'sd0;
		lo_m = 32'sd0;
		blim = 32'sd0;
		lvl = 3'h0;
		nxt_d = cur_q;
		nxt_d.strobe = 1'b0;
		// Bus side: acknowledge in the cycle after the request is seen.
		nxt_d.ack = (read | write) & ~cur_q.ack;
		if ((read | write) & ~cur_q.ack) begin
			nxt_d.rdata = 32'h0000_0000;
			if (read) begin
				case (address)
					OFF_CONFIG: nxt_d.rdata = cur_q.config_word;
					OFF_TOP: nxt_d.rdata = 32'(cur_q.top);
					OFF_BOTTOM: nxt_d.rdata = 32'(cur_q.bottom);
					// Margin word reads zero where margins are not offered.
					OFF_EXT: nxt_d.rdata = margins_on ? {5'h00, cur_q.ext_lower, 5'h00,
							cur_q.ext_upper} : 32'h0000_0000;
					OFF_THR1: nxt_d.rdata = 32'(cur_q.thr1);
					OFF_HYST1: nxt_d.rdata = 32'(cur_q.hyst1);
					OFF_THR2: nxt_d.rdata = 32'(cur_q.thr2);
					OFF_HYST2: nxt_d.rdata = 32'(cur_q.hyst2);
					OFF_BIAS: nxt_d.rdata = 32'(cur_q.bias);
					OFF_STATUS: nxt_d.rdata = {27'h0, cur_q.result_ok, cur_q.under,
							cur_q.over, cur_q.al2, cur_q.al1};
					OFF_VALUE: nxt_d.rdata = 32'(cur_q.value);
					OFF_PERCENT: nxt_d.rdata = 32'(cur_q.pct);
					OFF_NAME0: nxt_d.rdata = cur_q.name0;
					OFF_NAME1: nxt_d.rdata = cur_q.name1;
					OFF_NAME2: nxt_d.rdata = {24'h0, cur_q.name2[7:0]};
					OFF_UNIT: nxt_d.rdata = cur_q.unit_label;
					default: nxt_d.rdata = 32'h0000_0000;
				endcase
			end
		end
		// Writes land at the edge where waitrequest is low.
		if (write && cur_q.ack) begin
			case (address)
				OFF_CONFIG: begin
					nxt_d.config_word = {17'h0, writedata[14:0]};
					// Filter level above five is held at five.
					if (writedata[CFG_FILT_LSB +: 3] > FILT_MAX) begin
						nxt_d.config_word[CFG_FILT_LSB +: 3] = FILT_MAX;
					end
				end
				OFF_TOP: nxt_d.top = 16'(clamp(32'($signed(writedata[15:0])), SCALE_LIMIT));
				OFF_BOTTOM: nxt_d.bottom = 16'(clamp(32'($signed(writedata[15:0])),
						SCALE_LIMIT));
				OFF_EXT: begin
					nxt_d.ext_upper = writedata[10:0];
					nxt_d.ext_lower = writedata[EXT_LOWER_LSB +: 11];
				end
				// Thresholds and hysteresis are taken as written, unchecked.
				OFF_THR1: nxt_d.thr1 = writedata[15:0];
				OFF_HYST1: nxt_d.hyst1 = writedata[15:0];
				OFF_THR2: nxt_d.thr2 = writedata[15:0];
				OFF_HYST2: nxt_d.hyst2 = writedata[15:0];
				OFF_BIAS: nxt_d.bias = writedata[15:0];
				OFF_NAME0: nxt_d.name0 = writedata;
				OFF_NAME1: nxt_d.name1 = writedata;
				OFF_NAME2: nxt_d.name2 = {24'h0, writedata[7:0]};
				OFF_UNIT: nxt_d.unit_label = writedata;
				default: nxt_d.result_ok = cur_q.result_ok;
			endcase
		end
		// Sample path: capture, smooth, scale, then judge range and alarms.
		case (cur_q.state)
			ST_IDLE: begin
				if (sample_valid) begin
					if (type_live(in_type)) begin
						nxt_d.raw = sample_data;
						nxt_d.state = ST_FILTER;
					end else begin
						// Inactive channel: nothing to show, alarms dropped.
						nxt_d.result_ok = 1'b0;
						nxt_d.al1 = 1'b0;
						nxt_d.al2 = 1'b0;
						nxt_d.over = 1'b0;
						nxt_d.under = 1'b0;
						nxt_d.filt_primed = 1'b0;
					end
				end
			end
			ST_FILTER: begin
				// First-order smoother; each level doubles the time constant.
				lvl = filt_level;
				if (!cur_q.filt_primed || lvl == 3'h0) begin
					nxt_d.filt = 32'(cur_q.raw) <<< FILT_FRAC;
				end else begin
					nxt_d.filt = cur_q.filt + (((32'(cur_q.raw) <<< FILT_FRAC) - cur_q.filt)
							>>> lvl);
				end
				nxt_d.filt_primed = 1'b1;
				nxt_d.state = ST_SCALE;
			end
			ST_SCALE: begin
				if (is_span(in_type)) begin
					// Bottom point at span bottom, top point at span top; a bottom above the
					// top simply makes the slope negative.
					v = lo_pt + ((x - span_lo(in_type)) * (hi_pt - lo_pt)) /
							(span_hi(in_type) - span_lo(in_type));
				end else if (is_mv(in_type)) begin
					// Sensor-style range: the smaller point is always the bottom.
					if (lo_pt > hi_pt) begin
						v = hi_pt + (x * (lo_pt - hi_pt)) / span_hi(in_type);
					end else begin
						v = lo_pt + (x * (hi_pt - lo_pt)) / span_hi(in_type);
					end
				end else begin
					// Temperature in tenths of a degree, Celsius or Fahrenheit.
					v = cur_q.config_word[CFG_FAHR_BIT] ? (x * 9) / 5 + FAHR_OFFSET : x;
					blim = is_tc(in_type) ? BIAS_TC_LIMIT : BIAS_RTD_LIMIT;
					v = v + clamp(32'(cur_q.bias), blim);
				end
				// Range check against the span widened by its margins.
				if (margins_on) begin
					up_m = (32'(cur_q.ext_upper) > upper_lim(in_type)) ? upper_lim(in_type) :
							32'(cur_q.ext_upper);
					lo_m = (32'(cur_q.ext_lower) > lower_lim(in_type)) ? lower_lim(in_type) :
							32'(cur_q.ext_lower);
					nxt_d.over = x > span_hi(in_type) + up_m;
					// Zero-based spans ignore the lower margin entirely.
					nxt_d.under = (lower_lim(in_type) != 0) ? (x < span_lo(in_type) - lo_m) :
							(x < 0);
				end else begin
					nxt_d.over = 1'b0;
					nxt_d.under = 1'b0;
				end
				nxt_d.value = 16'(clamp(v, 32'sd32767));
				nxt_d.state = ST_ALARM;
			end
			ST_ALARM: begin
				// Out of range compares as the extreme of its direction, so an above
				// alarm stays on while over range and a below alarm while under.
				v = cur_q.over ? 32'sd32767 : (cur_q.under ? -32'sd32767 : 32'(cur_q.value));
				nxt_d.al1 = alarm_next(cur_q.al1, cur_q.config_word[CFG_DIR1_BIT], v,
						32'(cur_q.thr1), 32'(cur_q.hyst1));
				nxt_d.al2 = alarm_next(cur_q.al2, cur_q.config_word[CFG_DIR2_BIT], v,
						32'(cur_q.thr2), 32'(cur_q.hyst2));
				// Percent in tenths, relative to the range between the two points.
				hi_pt = (32'(cur_q.top) > 32'(cur_q.bottom)) ? 32'(cur_q.top) : 32'(cur_q.bottom);
				lo_pt = (32'(cur_q.top) > 32'(cur_q.bottom)) ? 32'(cur_q.bottom) : 32'(cur_q.top);
				if (hi_pt == lo_pt) begin
					nxt_d.pct = 16'sh0000;
				end else begin
					nxt_d.pct = 16'(clamp(((32'(cur_q.value) - lo_pt) * PERCENT_FULL) /
							(hi_pt - lo_pt), 32'sd32767));
				end
				nxt_d.result_ok = ~cur_q.over & ~cur_q.under;
				nxt_d.strobe = 1'b1;
				nxt_d.state = ST_IDLE;
			end
			default: nxt_d.state = ST_IDLE;
		endcase
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_q <= '0;
			cur_q.state <= ST_IDLE;
			cur_q.config_word <= CONFIG_RST;
			cur_q.top <= TOP_RST;
			cur_q.bottom <= BOTTOM_RST;
		end else if (clk_en) begin
			cur_q <= nxt_d;
		end
	end
endmodule : channel_scaling_and_alarms

/* bench/channel_scaling_and_alarms_chk.sv */
// Checker for the channel scaling and alarm block: sample timing, alarm and range updates.
// Assumes one clock, core_clk, with rst asynchronous and active high; bound below.
module channel_scaling_and_alarms_chk #(
	parameter bit TEMP_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire logic first_alarm,
	input wire logic second_alarm,
	input wire logic over_range_indication,
	input wire logic under_range_indication,
	input wire logic signed [15:0] display_value,
	input wire logic signed [15:0] percent_value,
	input wire logic [1:0] wire_count,
	input wire logic result_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// A sample is accepted when offered and the block is idle.
	sequence take_s;
		sample_valid && sample_ready && clk_en;
	endsequence
	// First cycle of a bus request; the master always leaves a gap between requests.
	sequence req_start_s;
		(read || write) && !$past(read || write);
	endsequence
	take_strobe_a: assert property (take_s |-> ##4 result_strobe)
		else $error("result strobe not four cycles after a take");
	ready_gap_a: assert property (take_s |=> !sample_ready [*3])
		else $error("sample ready returned early");
	strobe_pulse_a: assert property (result_strobe |=> !result_strobe)
		else $error("result strobe longer than one cycle");
	strobe_ready_a: assert property (result_strobe && clk_en |-> sample_ready)
		else $error("not ready in the result cycle");
	alarm_update_a: assert property ($changed(first_alarm) || $changed(second_alarm)
		|-> result_strobe)
		else $error("alarm moved outside a result");
	value_lead_a: assert property ($changed(display_value) || $changed(over_range_indication)
		|| $changed(under_range_indication) |=> result_strobe)
		else $error("value moved out of step with the result");
	percent_step_a: assert property ($changed(percent_value) |-> result_strobe)
		else $error("percent moved outside a result");
	range_excl_a: assert property (!(over_range_indication && under_range_indication))
		else $error("over and under together");
	wire_zero_a: assert property (!TEMP_VARIANT |-> wire_count == 2'h0)
		else $error("wire count shown without thermometer types");
	bus_answer_a: assert property (req_start_s |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not in the second cycle");
	bus_idle_a: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest without a request");
	freeze_hold_a: assert property (!clk_en |=> $stable(display_value) && $stable(first_alarm)
		&& $stable(second_alarm) && $stable(result_strobe))
		else $error("state moved while the clock enable was low");
endmodule : channel_scaling_and_alarms_chk
bind channel_scaling_and_alarms channel_scaling_and_alarms_chk #(
	.TEMP_VARIANT(TEMP_VARIANT)
) i_chk (
	.core_clk(core_clk),
	.rst(rst),
	.clk_en(clk_en),
	.read(read),
	.write(write),
	.waitrequest(waitrequest),
	.sample_valid(sample_valid),
	.sample_ready(sample_ready),
	.first_alarm(first_alarm),
	.second_alarm(second_alarm),
	.over_range_indication(over_range_indication),
	.under_range_indication(under_range_indication),
	.display_value(display_value),
	.percent_value(percent_value),
	.wire_count(wire_count),
	.result_strobe(result_strobe)
);

/* bench/sample_source.sv */
// Model of the converter that offers raw samples to the block.
// Assumes the block takes a sample on an edge where valid and ready are both high.
module sample_source (
	input wire logic core_clk,
	input wire logic sample_ready,
	output logic sample_valid,
	output logic signed [15:0] sample_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle until the first offer.
	initial begin
		sample_valid = 1'b0;
		sample_data = 16'sh0000;
	end
	// Offer one sample after gap cycles and hold it until taken; ok reports success.
	task automatic send(input logic signed [15:0] v, input int gap, output bit ok);
		int n;
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		sample_valid <= 1'b1;
		sample_data <= v;
		n = 0;
		// Ready is sampled at each rising edge; the edge that sees it high takes the sample.
		do begin
			@(posedge core_clk);
			n++;
		end while (sample_ready !== 1'b1 && n < 50);
		ok = (sample_ready === 1'b1);
		sample_valid <= 1'b0;
		// Released data is inverted so that a stale value is never mistaken for fresh.
		sample_data <= ~v;
	endtask : send
endmodule : sample_source

/* bench/tb_top.sv */
// Self-checking bench for the channel scaling and alarm block, current input variant.
// Assumes Avalon-MM registers answer in two cycles and results follow a take by four.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scale_alarm_pkg::*;
	logic core_clk, rst, clk_en, read, write, waitrequest, sample_valid, sample_ready;
	logic [5:0] address;
	logic [31:0] writedata, readdata;
	logic signed [15:0] sample_data, display_value, percent_value;
	logic first_alarm, second_alarm, over_range_indication, under_range_indication;
	logic [1:0] decimal_places, wire_count;
	logic result_strobe;
	int fails, num_checks, top_m, bot_m, thr1, h1, thr2, h2, filt, lvl;
	int seed = 32'h7ae78f07;
	bit d1, d2, a1, a2, have;
	logic [31:0] st_m, q;
	// The clock runs at 40 MHz.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	channel_scaling_and_alarms #(.TEMP_VARIANT(1'b0)) i_dut (.core_clk(core_clk), .rst(rst),
		.clk_en(clk_en), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
		.first_alarm(first_alarm), .second_alarm(second_alarm),
		.over_range_indication(over_range_indication),
		.under_range_indication(under_range_indication), .display_value(display_value),
		.percent_value(percent_value), .decimal_places(decimal_places),
		.wire_count(wire_count), .result_strobe(result_strobe));
	sample_source i_src (.core_clk(core_clk), .sample_ready(sample_ready),
		.sample_valid(sample_valid), .sample_data(sample_data));
	// Print the counts and the verdict, then stop.
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// Compare one value and report a mismatch at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// One Avalon access, held until waitrequest is seen low at a rising edge.
	task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		n = 0;
		// Waitrequest is sampled at each rising edge; the answering edge also carries the data.
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// A bus that never answers ends the run rather than hanging it.
		if (waitrequest !== 1'b0) begin
			fails++;
			finish_test();
		end
	endtask : bus
	// Configuration word; wire bits are always set to show they stay hidden for span inputs.
	function automatic logic [31:0] cfg(input int l, input int d, input bit x1, input bit x2);
		return 32'(IN_MA_4_20) | (32'(l) << CFG_FILT_LSB) | (32'(d) << CFG_DEC_LSB)
			| (32'h3 << CFG_WIRE_LSB) | (32'(x1) << CFG_DIR1_BIT) | (32'(x2) << CFG_DIR2_BIT);
	endfunction : cfg
	// Send one raw sample in hundredths of a mA and compare flags, status and, when in range, value and percent with the model.
	task automatic run(input int raw, input int gap);
		int v, av, n;
		bit ov, un, ok;
		filt = (lvl == 0 || !have) ? raw : filt + ((raw - filt) >>> lvl);
		have = 1'b1;
		ov = filt > 2000 + 100;
		un = filt < 400 - 100;
		v = bot_m + (filt - 400) * (top_m - bot_m) / 1600;
		av = ov ? 32767 : (un ? -32767 : v);
		// Hysteresis widens only the trip point; release is at the bare threshold.
		a1 = d1 ? (av > thr1 + (a1 ? 0 : h1)) : (av < thr1 - (a1 ? 0 : h1));
		a2 = d2 ? (av > thr2 + (a2 ? 0 : h2)) : (av < thr2 - (a2 ? 0 : h2));
		st_m = {27'h0, !(ov || un), un, ov, a2, a1};
		i_src.send(16'(raw), gap, ok);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (result_strobe !== 1'b1 && n < 20);
		if (!ok || n >= 20) begin
			fails++;
			finish_test();
		end
		check({first_alarm, second_alarm, over_range_indication, under_range_indication},
			{a1, a2, ov, un}, "flags");
		if (!ov && !un) begin
			check(32'(display_value), v, "value");
			check(32'(percent_value), v * 1000 / 1600, "percent");
		end
		bus(1'b0, OFF_STATUS, 32'h0);
		check(q & 32'h1F, st_m, "status");
	endtask : run
	// Main sequence.
	initial begin
		{rst, read, write, address, writedata} = {1'b1, 40'h0};
		{clk_en, fails, num_checks, have, a1, a2, filt} = {1'b1, 64'h0, 3'h0, 32'h0};
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, OFF_CONFIG, 32'h0);
		check(q, CONFIG_RST, "config reset");
		bus(1'b0, OFF_TOP, 32'h0);
		check(q, 32'(TOP_RST), "top reset");
		// Out-of-limit scale points are held at the limit.
		bus(1'b1, OFF_TOP, 32'(12000));
		bus(1'b1, OFF_BOTTOM, -32'sd12000);
		bus(1'b0, OFF_TOP, 32'h0);
		check(q, 32'(SCALE_LIMIT), "top limit");
		bus(1'b0, OFF_BOTTOM, 32'h0);
		check(q, -32'sd9999, "bottom limit");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFF_CONFIG, cfg(0, i, 1'b0, 1'b1));
			@(negedge core_clk);
			check(32'(decimal_places), i, "decimal places");
			check(32'(wire_count), 0, "wire count");
		end
		// A filter level above five reads back as five.
		bus(1'b1, OFF_CONFIG, cfg(7, 0, 1'b0, 1'b1));
		bus(1'b0, OFF_CONFIG, 32'h0);
		check(32'(q[CFG_FILT_LSB +: 3]), 32'd5, "filter limit");
		{top_m, bot_m, thr1, h1, thr2, h2, d1, d2, lvl} = {32'd1600, 32'd0, 32'd500, 32'd0,
			32'd1000, 32'd50, 2'b01, 32'd1};
		bus(1'b1, OFF_TOP, 32'(top_m));
		bus(1'b1, OFF_BOTTOM, 32'(bot_m));
		bus(1'b1, OFF_EXT, 32'h0064_0064);
		bus(1'b1, OFF_THR1, 32'(thr1));
		bus(1'b1, OFF_HYST1, 32'(h1));
		bus(1'b1, OFF_THR2, 32'(thr2));
		bus(1'b1, OFF_HYST2, 32'(h2));
		bus(1'b1, OFF_CONFIG, cfg(lvl, 0, d1, d2));
		// Smoothing: the first sample loads, later ones move half the way.
		run(400, 0);
		run(1200, 0);
		run(1200, 1);
		lvl = 0;
		bus(1'b1, OFF_CONFIG, cfg(lvl, 0, d1, d2));
		// Walk the second alarm across its hysteresis band and back to the threshold.
		run(1440, 0);
		run(1456, 0);
		run(1408, 0);
		run(1400, 0);
		// Status is read-only; a write must leave it alone.
		bus(1'b1, OFF_STATUS, 32'h0);
		bus(1'b0, OFF_STATUS, 32'h0);
		check(q & 32'h1F, st_m, "status after write");
		// A low clock enable freezes the block, so no sample may be offered as taken.
		clk_en <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(32'(sample_ready), 0, "frozen ready");
		clk_en <= 1'b1;
		repeat (40) run(1200 + 8 * ($random(seed) % 121), $random(seed) & 3);
		// Inverted scale and thresholds that are always met while in range.
		{top_m, bot_m, thr1, h1, thr2, h2, d1, d2} = {32'd0, 32'd1600, -32'sd9999, 32'd0,
			32'd9999, 32'd0, 2'b10};
		bus(1'b1, OFF_TOP, 32'(top_m));
		bus(1'b1, OFF_BOTTOM, 32'(bot_m));
		bus(1'b1, OFF_THR1, 32'(thr1));
		bus(1'b1, OFF_HYST2, 32'(h2));
		bus(1'b1, OFF_THR2, 32'(thr2));
		bus(1'b1, OFF_CONFIG, cfg(lvl, 3, d1, d2));
		repeat (40) run(1200 + 8 * ($random(seed) % 121), $random(seed) & 3);
		finish_test();
	end
endmodule : tb_top
